// ===== include/node_ctrl_pkg.sv
// Package: register map, field positions, reset values and timing counts
// Assumes a 100 MHz core clock and 32-bit APB data.
package node_ctrl_pkg;
	localparam int CLK_MHZ = 100;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_NODEID = 8'h04;
	localparam logic [7:0] OFF_DIAG = 8'h08;
	localparam logic [7:0] OFF_IRQ = 8'h0c;
	localparam logic [7:0] OFF_EXTIRQ = 8'h10;
	localparam logic [7:0] OFF_MASKA = 8'h14;
	localparam logic [7:0] OFF_MASKB = 8'h18;
	localparam logic [7:0] OFF_ACTMAP = 8'h1c;
	localparam logic [7:0] OFF_SPDMAP = 8'h20;
	localparam logic [7:0] OFF_GTIMER = 8'h24;
	localparam logic [7:0] OFF_STIMER = 8'h28;
	localparam logic [7:0] OFF_RETRY = 8'h2c;
	localparam logic [7:0] OFF_BCTIMER = 8'h30;
	localparam logic [7:0] OFF_STATUS = 8'h34;
	// Control register bits
	localparam int C_TXON = 0;
	localparam int C_CYCON = 1;
	localparam int C_CYCSRC = 2;
	localparam int C_CONCAT = 3;
	localparam int C_ACKSP = 4;
	localparam int C_RXFLUSH = 5;
	localparam int C_ISOFLUSH = 6;
	localparam int C_ISOSEL = 7;
	localparam int C_KEEPSID = 8;
	localparam int C_GTSTART = 9;
	localparam int C_GTREPEAT = 10;
	localparam int C_RETRYDUAL = 11;
	localparam int C_STSTART = 12;
	// Node id bits
	localparam int N_VALID = 31;
	localparam int N_ROOT = 30;
	localparam int N_RMVALID = 29;
	localparam int N_RMLO = 8;
	localparam int N_IDLO = 0;
	// Diagnostic bits
	localparam int D_ATPEND = 0;
	localparam int D_ITPEND = 1;
	// Interrupt factor bits
	localparam int I_CFG = 0;
	localparam int I_GT = 1;
	localparam int I_STO = 2;
	localparam int I_RETRY = 3;
	localparam int I_BUSRST = 4;
	localparam int I_SIDERR = 5;
	localparam int I_EXT = 31;
	localparam int IRQ_W = 32;
	// Reset values
	localparam logic [5:0] RM_NUMBER_RST = 6'h3f;
	localparam logic [31:0] RETRY_RST = 32'h0000_0000;
	// Configuration timer points
	localparam int CFG_T1_US = 125;
	localparam int CFG_T2_US = 625;
	localparam int CFG_T3_US = 1000000;
	localparam int CFG_T1_CYC = CFG_T1_US * CLK_MHZ;
	localparam int CFG_T2_CYC = CFG_T2_US * CLK_MHZ;
	localparam int CFG_T3_CYC = CFG_T3_US * CLK_MHZ;
	localparam int RETRY_PHASE_CYC = 64;
endpackage

// ===== rtl/selfid_analyzer.sv
// Self-ID quadlet checker: builds node maps and root/manager numbers
// Assumes quadlet pairs (data then inverse) on the core clock.
`timescale 1ns/1ns
`default_nettype none
module selfid_analyzer (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        clearMaps,
	// Quadlet stream
	input  wire logic        quadValid,
	input  wire logic [31:0] quadData,
	// Results
	output logic      [63:0] activeMap,
	output logic      [63:0] speedMap,
	output logic      [5:0]  rootNumber,
	output logic      [5:0]  rmNumber,
	output logic             rmFound,
	output logic             seqError,
	output logic             anyPacket
);
	import node_ctrl_pkg::*;
	logic        haveData;
	logic [31:0] firstQuad;
	logic [5:0]  expectNode;
	logic [5:0]  phyId;

	assign phyId = firstQuad[29:24];

	always_ff @(posedge core_clk) begin
		if (!rst_n || clearMaps) begin
			haveData   <= 1'b0;
			firstQuad  <= 32'h0000_0000;
			expectNode <= 6'h00;
			activeMap  <= 64'h0;
			speedMap   <= 64'h0;
			rootNumber <= 6'h00;
			rmNumber   <= RM_NUMBER_RST;
			rmFound    <= 1'b0;
			seqError   <= 1'b0;
			anyPacket  <= 1'b0;
		end else if (quadValid) begin
			if (!haveData) begin
				firstQuad <= quadData;
				haveData  <= 1'b1;
			end else begin
				haveData <= 1'b0;
				if (quadData != ~firstQuad) begin
					seqError <= 1'b1;
				end else if (phyId != expectNode) begin
					seqError <= 1'b1;
				end else begin
					anyPacket  <= 1'b1;
					expectNode <= phyId + 6'h01;
					rootNumber <= phyId;
					activeMap[phyId] <= firstQuad[22];
					speedMap[phyId]  <= firstQuad[14];
					if (firstQuad[11] && firstQuad[22]) begin
						rmNumber <= phyId;
						rmFound  <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/bus_reset_node_control.sv
// Node control: bus reset actions, self-ID results, timers, interrupts
// Assumes an APB master on core_clk and phy signals from another domain.
// Summary of operation
// - Bus reset clears both transmit-pending flags
// - Bus reset clears valid, root, manager flags
// - Bus reset clears active and speed maps
// - Bus reset reloads retry and reset state
// - Bus reset reloads configuration timer; end of self-ID starts it
// - Configuration timer flags at 125us, 625us, 1s
// - Bus reset flushes queues per options
// - Self-ID kept per option, root then settled
// - Analysis checks inverse, continuity, contender, link, speed
// - Analysis yields root, manager, active and speed maps
// - Cycle start needs all enables and root
// - General timer repeats or fires once
// - Split timeout flags at preset count
// - Retry timer self-started, single or dual phase
// - Factors latch into sticky flags that drive interrupt outputs
// - Extended bit is OR of extended factors
// - Masks route factors; masked factor is silent
// - Concatenate channels when enabled and iso multi-channel is set
`timescale 1ns/1ns
`default_nettype none
module bus_reset_node_control #(
	parameter int CFG_T3 = node_ctrl_pkg::CFG_T3_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [node_ctrl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Physical layer
	input  wire logic        phyBusReset,
	input  wire logic        selfidValid,
	input  wire logic [31:0] selfidData,
	input  wire logic        selfidDone,
	// Link core events
	input  wire logic        asyncTxStart,
	input  wire logic        isoTxStart,
	input  wire logic [7:0]  extEvents,
	input  wire logic        isoMultiChannel,
	// Queue controls and feature enables
	output logic             flushAsyncTxInt,
	output logic             flushAsyncRxInt,
	output logic             flushAsyncRx,
	output logic             flushIsoTx,
	output logic             storeSelfid,
	output logic [31:0]      storeSelfidData,
	output logic             cycleStartOn,
	output logic             concatOn,
	output logic             ackSpeedupOn,
	// Interrupts
	output logic             irq_out_a_n,
	output logic             irq_out_b_n
);
	import node_ctrl_pkg::*;

	if (CFG_T3 <= CFG_T2_CYC) begin
		$error("CFG_T3 must exceed 625 us count");
	end

	logic [2:0]  rstSync;
	logic        busRstLevel;
	logic        busRstPulse;
	logic [31:0] ctrl;
	logic        nodeValid;
	logic        rootFlag;
	logic        rmValid;
	logic [5:0]  rmNumberReg;
	logic [1:0]  diag;
	logic [31:0] irqFlags;
	logic [31:0] extFlags;
	logic [31:0] maskA;
	logic [31:0] maskB;
	logic [31:0] gtInterval;
	logic [31:0] gtCount;
	logic        gtRun;
	logic [31:0] stPreset;
	logic [31:0] stCount;
	logic [31:0] retryReg;
	logic [7:0]  retryCount;
	logic        retryPhase;
	logic [31:0] cfgCount;
	logic        cfgRun;
	logic        resetSeen;
	logic        selfidSeen;
	logic [63:0] activeMap;
	logic [63:0] speedMap;
	logic [5:0]  rootNumber;
	logic [5:0]  rmNumber;
	logic        rmFound;
	logic        seqError;
	logic        anyPacket;
	logic [31:0] setIrq;
	logic [31:0] setExt;
	logic        accessWr;
	logic        accessRd;
	logic [31:0] next_rdata;
	logic        mapped;

	function automatic logic hitAddr(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hitAddr = (a == off);
	endfunction

	// Phy reset synchroniser, change counts when stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rstSync     <= 3'h0;
			busRstLevel <= 1'b0;
		end else begin
			rstSync <= {rstSync[1:0], phyBusReset};
			if (rstSync[1] == rstSync[2]) begin
				busRstLevel <= rstSync[2];
			end
		end
	end
	assign busRstPulse = rstSync[1] && rstSync[2] && !busRstLevel;

	assign accessWr = psel && penable && pwrite;
	assign accessRd = psel && penable && !pwrite;

	// Control, mask and timer setting registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl  <= 32'h0000_0000;
			maskA <= 32'h0000_0000;
			maskB <= 32'h0000_0000;
			gtInterval <= 32'h0000_0000;
			stPreset   <= 32'h0000_0000;
		end else if (accessWr) begin
			if (hitAddr(paddr, OFF_CTRL)) ctrl <= pwdata;
			if (hitAddr(paddr, OFF_MASKA)) maskA <= pwdata;
			if (hitAddr(paddr, OFF_MASKB)) maskB <= pwdata;
			if (hitAddr(paddr, OFF_GTIMER)) gtInterval <= pwdata;
			if (hitAddr(paddr, OFF_STIMER)) stPreset <= pwdata;
		end
	end

	// Node identification
	always_ff @(posedge core_clk) begin
		if (!rst_n || busRstPulse) begin
			nodeValid   <= 1'b0;
			rootFlag    <= 1'b0;
			rmValid     <= 1'b0;
			rmNumberReg <= RM_NUMBER_RST;
			selfidSeen  <= 1'b0;
		end else if (selfidDone && !selfidSeen) begin
			selfidSeen  <= 1'b1;
			nodeValid   <= anyPacket && !seqError;
			rootFlag    <= anyPacket && !seqError;
			rmValid     <= rmFound;
			rmNumberReg <= rmNumber;
		end
	end

	// Diagnostic pending flags
	always_ff @(posedge core_clk) begin
		if (!rst_n || busRstPulse) begin
			diag <= 2'b00;
		end else begin
			if (asyncTxStart) diag[D_ATPEND] <= 1'b1;
			if (isoTxStart) diag[D_ITPEND] <= 1'b1;
		end
	end

	// Self-ID analysis
	selfid_analyzer u_sid (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.clearMaps  (busRstPulse),
		.quadValid  (selfidValid && !selfidSeen),
		.quadData   (selfidData),
		.activeMap  (activeMap),
		.speedMap   (speedMap),
		.rootNumber (rootNumber),
		.rmNumber   (rmNumber),
		.rmFound    (rmFound),
		.seqError   (seqError),
		.anyPacket  (anyPacket)
	);

	// Queue flushes and self-ID storage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flushAsyncTxInt <= 1'b0;
			flushAsyncRxInt <= 1'b0;
			flushAsyncRx    <= 1'b0;
			flushIsoTx      <= 1'b0;
			storeSelfid     <= 1'b0;
			storeSelfidData <= 32'h0000_0000;
		end else begin
			flushAsyncTxInt <= busRstPulse;
			flushAsyncRxInt <= busRstPulse;
			flushAsyncRx    <= busRstPulse && ctrl[C_RXFLUSH];
			flushIsoTx      <= busRstPulse && !ctrl[C_ISOSEL] && ctrl[C_ISOFLUSH];
			storeSelfid     <= selfidValid && !selfidSeen && ctrl[C_KEEPSID];
			storeSelfidData <= selfidData;
		end
	end

	// Configuration timer, started at end of self-ID
	always_ff @(posedge core_clk) begin
		if (!rst_n || busRstPulse) begin
			cfgCount  <= 32'h0000_0000;
			cfgRun    <= 1'b0;
			resetSeen <= !rst_n ? 1'b0 : 1'b1;
		end else begin
			if (resetSeen && selfidDone && !cfgRun && cfgCount == 32'h0) begin
				cfgRun <= 1'b1;
			end
			if (cfgRun) begin
				if (cfgCount == 32'(CFG_T3)) cfgRun <= 1'b0;
				else cfgCount <= cfgCount + 32'h1;
			end
		end
	end

	// General timer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			gtCount <= 32'h0000_0000;
			gtRun   <= 1'b0;
		end else if (accessWr && hitAddr(paddr, OFF_CTRL) && pwdata[C_GTSTART]) begin
			gtCount <= 32'h0000_0000;
			gtRun   <= 1'b1;
		end else if (gtRun) begin
			if (gtCount >= gtInterval) begin
				gtCount <= 32'h0000_0000;
				gtRun   <= ctrl[C_GTREPEAT];
			end else begin
				gtCount <= gtCount + 32'h1;
			end
		end
	end

	// Split timeout timer
	always_ff @(posedge core_clk) begin
		if (!rst_n || !ctrl[C_STSTART]) begin
			stCount <= 32'h0000_0000;
		end else if (stCount != stPreset) begin
			stCount <= stCount + 32'h1;
		end
	end

	// Retry timer, self started on bus reset
	always_ff @(posedge core_clk) begin
		if (!rst_n || busRstPulse) begin
			retryReg   <= RETRY_RST;
			retryCount <= 8'h00;
			retryPhase <= 1'b0;
		end else if (retryCount == 8'(RETRY_PHASE_CYC - 1)) begin
			retryCount <= 8'h00;
			retryPhase <= ctrl[C_RETRYDUAL] ? !retryPhase : 1'b0;
			retryReg   <= retryReg + 32'h1;
		end else begin
			retryCount <= retryCount + 8'h01;
		end
	end

	// Interrupt events
	always_comb begin
		setIrq = 32'h0000_0000;
		setIrq[I_CFG] = cfgRun && (cfgCount == 32'(CFG_T1_CYC) || cfgCount == 32'(CFG_T2_CYC)
			|| cfgCount == 32'(CFG_T3));
		setIrq[I_GT] = gtRun && gtCount >= gtInterval;
		setIrq[I_STO] = ctrl[C_STSTART] && stPreset != 32'h0
			&& stCount + 32'h1 == stPreset;
		setIrq[I_RETRY] = retryCount == 8'(RETRY_PHASE_CYC - 1) && retryPhase;
		setIrq[I_BUSRST] = busRstPulse;
		setIrq[I_SIDERR] = selfidDone && !selfidSeen && seqError;
		setExt = {24'h0, extEvents};
	end

	// Sticky flags, set wins over write-one-to-clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqFlags <= 32'h0000_0000;
			extFlags <= 32'h0000_0000;
		end else begin
			if (accessWr && hitAddr(paddr, OFF_IRQ)) begin
				irqFlags <= (irqFlags & ~pwdata) | setIrq;
			end else begin
				irqFlags <= irqFlags | setIrq;
			end
			if (accessWr && hitAddr(paddr, OFF_EXTIRQ)) begin
				extFlags <= (extFlags & ~pwdata) | setExt;
			end else begin
				extFlags <= extFlags | setExt;
			end
		end
	end

	// Output pins and feature enables
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_out_a_n  <= 1'b1;
			irq_out_b_n  <= 1'b1;
			cycleStartOn <= 1'b0;
			concatOn     <= 1'b0;
			ackSpeedupOn <= 1'b0;
		end else begin
			irq_out_a_n  <= ~|({(|extFlags), irqFlags[30:0]} & ~maskA);
			irq_out_b_n  <= ~|({(|extFlags), irqFlags[30:0]} & ~maskB);
			cycleStartOn <= ctrl[C_TXON] && ctrl[C_CYCON] && ctrl[C_CYCSRC] && rootFlag;
			concatOn     <= ctrl[C_CONCAT] && isoMultiChannel;
			ackSpeedupOn <= ctrl[C_ACKSP];
		end
	end

	// Read decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		mapped = 1'b1;
		unique case (paddr)
			OFF_CTRL: next_rdata = ctrl;
			OFF_NODEID: next_rdata = {nodeValid, rootFlag, rmValid, 15'h0,
				rmNumberReg, 2'b00, rootNumber};
			OFF_DIAG: next_rdata = {30'h0, diag};
			OFF_IRQ: next_rdata = {(|extFlags), irqFlags[30:0]};
			OFF_EXTIRQ: next_rdata = extFlags;
			OFF_MASKA: next_rdata = maskA;
			OFF_MASKB: next_rdata = maskB;
			OFF_ACTMAP: next_rdata = activeMap[31:0];
			OFF_SPDMAP: next_rdata = speedMap[31:0];
			OFF_GTIMER: next_rdata = gtInterval;
			OFF_STIMER: next_rdata = stPreset;
			OFF_RETRY: next_rdata = retryReg;
			OFF_BCTIMER: next_rdata = cfgCount;
			OFF_STATUS: next_rdata = {29'h0, busRstLevel, cfgRun, gtRun};
			default: mapped = 1'b0;
		endcase
	end

	// APB answer: no wait states, ready in the first access cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) prdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== test/bus_reset_node_control_assertions.sv
// Checker: flush pulses, APB answer timing and enable outputs
// Assumes it is bound to the node control top module.
`timescale 1ns/1ns
`default_nettype none
module bus_reset_node_control_assertions #(
	parameter int CFG_T3 = 70000
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// APB
	input  wire logic psel,
	input  wire logic penable,
	input  wire logic pwrite,
	input  wire logic pready,
	input  wire logic pslverr,
	// Bus reset and queues
	input  wire logic phyBusReset,
	input  wire logic flushAsyncTxInt,
	input  wire logic flushAsyncRxInt,
	input  wire logic flushAsyncRx,
	input  wire logic flushIsoTx,
	// Enables
	input  wire logic cycleStartOn,
	input  wire logic isoMultiChannel,
	input  wire logic concatOn,
	input  wire logic ackSpeedupOn
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	quick_ready_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	err_in_access_a: assert property (pslverr |-> pready)
		else $error("error outside access");
	reset_flush_a: assert property ($rose(phyBusReset) |-> ##[2:8] flushAsyncTxInt)
		else $error("no flush after bus reset");
	flush_pair_a: assert property ((flushAsyncTxInt || flushAsyncRxInt) |->
		flushAsyncTxInt && flushAsyncRxInt && $past(phyBusReset))
		else $error("internal flushes differ");
	flush_pulse_a: assert property (flushAsyncTxInt |=> !flushAsyncTxInt)
		else $error("flush longer than a cycle");
	rx_flush_cause_a: assert property (flushAsyncRx |-> flushAsyncTxInt)
		else $error("receive flush without reset");
	iso_flush_cause_a: assert property (flushIsoTx |-> flushAsyncTxInt)
		else $error("iso flush without reset");
	cycle_stop_a: assert property (flushAsyncTxInt |-> ##[0:2] !cycleStartOn)
		else $error("cycle start kept after reset");
	concat_write_a: assert property ($changed(concatOn) |->
		$past(psel && penable && pwrite, 2)
		|| $past(isoMultiChannel) != $past(isoMultiChannel, 2))
		else $error("concat enable moved alone");
	accel_write_a: assert property ($changed(ackSpeedupOn) |->
		$past(psel && penable && pwrite, 2))
		else $error("accel enable moved alone");
endmodule
bind bus_reset_node_control bus_reset_node_control_assertions #(.CFG_T3(CFG_T3)) i_chk (
	.core_clk, .rst_n, .psel, .penable, .pwrite, .pready, .pslverr, .phyBusReset,
	.flushAsyncTxInt, .flushAsyncRxInt, .flushAsyncRx, .flushIsoTx, .cycleStartOn,
	.concatOn, .ackSpeedupOn, .isoMultiChannel
);
`default_nettype wire

// ===== test/phy_link_model.sv
// Phy model: bus reset level, self-ID quadlet pairs, end of self-ID
// Assumes the bench pulses start for one cycle and waits for busy low.
`timescale 1ns/1ns
`default_nettype none
module phy_link_model (
	// Clock
	input  wire logic       core_clk,
	// Bench control
	input  wire logic       start,
	input  wire logic [5:0] nodes,
	input  wire logic       corrupt,
	// Toward the link
	output logic            phyBusReset,
	output logic            selfidValid,
	output logic [31:0]     selfidData,
	output logic            selfidDone,
	output logic            busy
);
	logic [31:0] q;
	initial begin
		phyBusReset = 1'b0;
		selfidValid = 1'b0;
		selfidData = 32'h5a5a_a5a5;
		selfidDone = 1'b0;
		busy = 1'b0;
	end
	always @(posedge core_clk) if (start) begin
		busy <= 1'b1;
		phyBusReset <= 1'b1;
		repeat (8) @(posedge core_clk);
		phyBusReset <= 1'b0;
		repeat (4) @(posedge core_clk);
		// Link active, odd nodes contend and run fast
		for (int i = 0; i < int'(nodes); i++) begin
			q = {2'b10, 6'(i), 2'b01, 6'h3f, 1'b1, 1'(i % 2), 2'b00, 1'(i % 2), 11'h0};
			selfidValid <= 1'b1;
			selfidData <= q;
			@(posedge core_clk);
			selfidData <= ~q ^ {31'h0, corrupt};
			@(posedge core_clk);
		end
		selfidValid <= 1'b0;
		selfidData <= ~selfidData;
		selfidDone <= 1'b1;
		@(posedge core_clk);
		selfidDone <= 1'b0;
		selfidData <= ~selfidData;
		busy <= 1'b0;
	end
endmodule
`default_nettype wire

// ===== test/bus_reset_node_control_bench.sv
// Bench: APB register traffic, phy model, flush and interrupt checks
// Assumes node_ctrl_pkg is compiled first; one-second count shortened.
`timescale 1ns/1ns
`default_nettype none
module bus_reset_node_control_bench;
	import node_ctrl_pkg::*;
	localparam int T3 = 70000;
	logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, extEvents = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, selfidData, r, seed = 32'h0001_8515;
	logic        pready, pslverr, err, phyBusReset, selfidValid, selfidDone, busy;
	logic        asyncTxStart = 1'b0, isoTxStart = 1'b0, isoMulti = 1'b0;
	logic        start = 1'b0, corrupt = 1'b0, sawAq, sawRx, sawIso;
	logic [5:0]  nodes = 6'h01;
	logic        fAtx, fArx, fRx, fIso, storeSelfid, cycleStartOn, concatOn, ackSpeedupOn;
	logic [31:0] sidWord, sidSum;
	logic        irq_out_a_n, irq_out_b_n;
	int          miscompares = 0, numChecks = 0, storeCnt = 0, cyc = 0, t0 = 0, el;
	int          pts[3] = '{CFG_T1_CYC, CFG_T2_CYC, T3};

	always #5 core_clk = ~core_clk;
	// Sticky monitors cleared by each bus reset request
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (selfidDone) t0 <= cyc;
		sawAq <= start ? 1'b0 : (sawAq | (fAtx & fArx));
		sawRx <= start ? 1'b0 : (sawRx | fRx);
		sawIso <= start ? 1'b0 : (sawIso | fIso);
		storeCnt <= start ? 0 : storeCnt + int'(storeSelfid === 1'b1);
		sidSum <= start ? 32'h0 : sidSum + (storeSelfid === 1'b1 ? sidWord : 32'h0);
	end

	bus_reset_node_control #(.CFG_T3(T3)) i_dut (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phyBusReset(phyBusReset), .selfidValid(selfidValid),
		.selfidData(selfidData), .selfidDone(selfidDone), .asyncTxStart(asyncTxStart),
		.isoTxStart(isoTxStart), .extEvents(extEvents), .isoMultiChannel(isoMulti),
		.flushAsyncTxInt(fAtx), .flushAsyncRxInt(fArx), .flushAsyncRx(fRx),
		.flushIsoTx(fIso), .storeSelfid(storeSelfid), .storeSelfidData(sidWord),
		.cycleStartOn(cycleStartOn), .concatOn(concatOn), .ackSpeedupOn(ackSpeedupOn),
		.irq_out_a_n(irq_out_a_n), .irq_out_b_n(irq_out_b_n)
	);
	phy_link_model i_phy (
		.core_clk(core_clk), .start(start), .nodes(nodes), .corrupt(corrupt),
		.phyBusReset(phyBusReset), .selfidValid(selfidValid), .selfidData(selfidData),
		.selfidDone(selfidDone), .busy(busy)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic stop_test;
		if (miscompares == 0 && numChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) begin
			miscompares++;
			stop_test();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic busRst(input logic [5:0] n, input logic c);
		int k;
		k = 0;
		nodes <= n;
		corrupt <= c;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		do begin
			@(posedge core_clk);
			k++;
		end while ((busy !== 1'b0 || k < 2) && k < 400);
		if (k >= 400) begin
			miscompares++;
			stop_test();
		end
		repeat (4) @(posedge core_clk);
	endtask
	task automatic waitA(input int lim);
		int k;
		k = 0;
		while (irq_out_a_n !== 1'b0 && k < lim) begin
			@(posedge core_clk);
			k++;
		end
		if (k >= lim) begin
			miscompares++;
			stop_test();
		end
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		check({irq_out_a_n, irq_out_b_n}, 2'b11);
		apb(1'b0, OFF_NODEID, 32'h0);
		check({r[N_RMVALID], r[N_RMLO+:6]}, {1'b0, RM_NUMBER_RST});
		apb(1'b0, 8'hfc, 32'h0);
		check({31'h0, err}, 32'h0000_0001);
		check(r, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			isoMulti <= seed[0];
			apb(1'b1, OFF_MASKA, seed);
			apb(1'b0, OFF_MASKA, 32'h0);
			check(r, seed);
			apb(1'b1, OFF_CTRL, seed & 32'h0000_0018);
			@(posedge core_clk);
			check({concatOn, ackSpeedupOn}, {seed[C_CONCAT] & seed[0], seed[C_ACKSP]});
		end
		asyncTxStart <= 1'b1;
		isoTxStart <= 1'b1;
		@(posedge core_clk);
		asyncTxStart <= 1'b0;
		isoTxStart <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, OFF_DIAG, 32'h0);
		check(r[1:0], 2'b11);
		apb(1'b1, OFF_MASKA, ~(32'h1 << I_BUSRST));
		apb(1'b1, OFF_MASKB, 32'hffff_ffff);
		busRst(6'h03, 1'b0);
		apb(1'b0, OFF_DIAG, 32'h0);
		check(r[1:0], 2'b00);
		apb(1'b0, OFF_NODEID, 32'h0);
		check({r[N_RMVALID], r[N_RMLO+:6]}, 7'h41);
		apb(1'b0, OFF_ACTMAP, 32'h0);
		check(r, 32'h0000_0007);
		apb(1'b0, OFF_SPDMAP, 32'h0);
		check(r, 32'h0000_0002);
		apb(1'b0, OFF_RETRY, 32'h0);
		check(r, RETRY_RST);
		check({irq_out_a_n, irq_out_b_n}, 2'b01);
		apb(1'b1, OFF_IRQ, 32'h1 << I_BUSRST);
		@(posedge core_clk);
		check(irq_out_a_n, 1'b1);
		busRst(6'h01, 1'b0);
		apb(1'b0, OFF_ACTMAP, 32'h0);
		check(r, 32'h0000_0001);
		apb(1'b0, OFF_SPDMAP, 32'h0);
		check(r, 32'h0000_0000);
		apb(1'b0, OFF_NODEID, 32'h0);
		check({r[N_RMVALID], r[N_RMLO+:6]}, {1'b0, RM_NUMBER_RST});
		busRst(6'h02, 1'b1);
		apb(1'b0, OFF_IRQ, 32'h0);
		check(r[I_SIDERR], 1'b1);
		apb(1'b1, OFF_MASKA, 32'hffff_ffff);
		apb(1'b1, OFF_MASKB, ~(32'h1 << I_EXT));
		extEvents <= seed[7:0] | 8'h01;
		@(posedge core_clk);
		extEvents <= 8'h00;
		repeat (2) @(posedge core_clk);
		check({irq_out_a_n, irq_out_b_n}, 2'b10);
		apb(1'b0, OFF_EXTIRQ, 32'h0);
		apb(1'b1, OFF_EXTIRQ, r);
		apb(1'b0, OFF_IRQ, 32'h0);
		check({r[I_EXT], irq_out_b_n}, 2'b01);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, OFF_CTRL, (32'(k) << C_RXFLUSH) | (32'(k % 2) << C_KEEPSID));
			busRst(6'h02, 1'b0);
			check(sawAq, 1'b1);
			check({sawRx, sawIso}, {k[0], k[1] & ~k[2]});
			check(storeCnt, k[0] ? 32'h4 : 32'h0);
			check(sidSum, k[0] ? 32'hffff_fffe : 32'h0);
		end
		apb(1'b1, OFF_GTIMER, 32'h0000_0014);
		apb(1'b1, OFF_STIMER, 32'h0000_0014);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, OFF_CTRL, 32'h0);
			apb(1'b1, OFF_IRQ, 32'hffff_ffff);
			apb(1'b1, OFF_CTRL, (32'h1 << C_GTSTART) | (32'h1 << C_STSTART)
				| (32'(m) << C_GTREPEAT) | (32'(m) << C_RETRYDUAL));
			repeat (140) @(posedge core_clk);
			apb(1'b0, OFF_IRQ, 32'h0);
			check({r[I_STO], r[I_GT]}, 2'b11);
			apb(1'b1, OFF_IRQ, 32'hffff_ffff);
			repeat (140) @(posedge core_clk);
			apb(1'b0, OFF_IRQ, 32'h0);
			check({r[I_RETRY], r[I_STO], r[I_GT]}, {m[0], 1'b0, m[0]});
		end
		seed = lfsr(seed);
		apb(1'b1, OFF_CTRL, {29'h0, seed[2:0]});
		@(posedge core_clk);
		check(cycleStartOn, &seed[2:0]);
		apb(1'b1, OFF_CTRL, 32'h0000_0007);
		@(posedge core_clk);
		check(cycleStartOn, 1'b1);
		apb(1'b1, OFF_MASKA, ~32'h1);
		apb(1'b1, OFF_MASKB, 32'hffff_ffff);
		apb(1'b1, OFF_IRQ, 32'hffff_ffff);
		busRst(6'h02, 1'b0);
		for (int p = 0; p < 3; p++) begin
			waitA(pts[p] + 100 - (cyc - t0));
			el = cyc - t0;
			check(el >= pts[p] - 32 && el < pts[p] + 64, 1'b1);
			apb(1'b1, OFF_IRQ, 32'h1 << I_CFG);
			@(posedge core_clk);
			check(irq_out_a_n, 1'b1);
		end
		stop_test();
	end
endmodule
`default_nettype wire
